// ---- logic/wgsd_defs.vh ----
`ifndef WGSD_DEFS_VH
`define WGSD_DEFS_VH
// register offsets on the plain register port
`define WGSD_ADDR_W 3
`define WGSD_OFF_CTRL0 3'h0
`define WGSD_OFF_SDCTL 3'h1
`define WGSD_OFF_SDSRC 3'h2
`define WGSD_OFF_STAT 3'h3
// control register zero fields
`define WGSD_BIT_EN 7
`define WGSD_BIT_LD 6
`define WGSD_MODE_HI 2
`define WGSD_MODE_LO 0
`define WGSD_CTRL0_RST 8'h00
// shutdown control register fields
`define WGSD_BIT_SD 7
`define WGSD_BIT_REN 6
`define WGSD_BD_HI 5
`define WGSD_BD_LO 4
`define WGSD_AC_HI 3
`define WGSD_AC_LO 2
`define WGSD_SDCTL_RST 8'h14
// writable shutdown control bits, low two unimplemented
`define WGSD_SDCTL_MASK_LEVELS 8'hFC
// shutdown source enable bits
`define WGSD_SRC_CMP1 0
`define WGSD_SRC_CMP2 1
`define WGSD_SRC_LC2 2
`define WGSD_SRC_PIN 3
`define WGSD_SRC_W 4
`define WGSD_SDSRC_RST 8'h00
// status register bit
`define WGSD_BIT_IRQ 0
// override level encodings
`define WGSD_LVL_ONE 2'h3
`define WGSD_LVL_ZERO 2'h2
`define WGSD_LVL_TRI 2'h1
`define WGSD_LVL_INACT 2'h0
// mode encodings
`define WGSD_MODE_ASTEER 3'h0
`define WGSD_MODE_SSTEER 3'h1
`define WGSD_MODE_FWD 3'h2
`define WGSD_MODE_REV 3'h3
`define WGSD_MODE_HALF 3'h4
`define WGSD_MODE_PP 3'h5
`endif

// ---- logic/wgsd_sync.v ----
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser for a bus of async levels
module wgsd_sync #(
    parameter W = 1
) (
    // clock and reset
    input wire i_core_clk,
    input wire i_arst_n,
    // async in, synced out
    input wire [W-1:0] i_async,
    output wire [W-1:0] o_sync
);
    reg [W-1:0] meta_r; // first stage, read only by second
    reg [W-1:0] sync_r; // second stage
    // plain double flop
    always @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            meta_r <= {W{1'b0}};
            sync_r <= {W{1'b0}};
        end else begin
            meta_r <= i_async;
            sync_r <= meta_r;
        end
    end
    assign o_sync = sync_r;
endmodule // wgsd_sync
`default_nettype wire

// ---- logic/wgsd_ovr.v ----
`timescale 1ns/1ps
`default_nettype none
`include "wgsd_defs.vh"
// maps a two-bit override field onto one output pin
module wgsd_ovr (
    // field, polarity, normal drive
    input wire [1:0] i_level,
    input wire i_pol,
    input wire i_shut,
    input wire i_norm,
    // pin drive
    output reg o_val,
    output reg o_oe
);
    // polarity never touches fixed override levels
    always @* begin
        o_val = i_norm;
        o_oe = 1'b1;
        if (i_shut) begin
            case (i_level)
                `WGSD_LVL_ONE: o_val = 1'b1;
                `WGSD_LVL_ZERO: o_val = 1'b0;
                `WGSD_LVL_TRI: begin
                    o_val = 1'b0;
                    o_oe = 1'b0;
                end
                default: o_val = i_pol; // inactive, polarity applied
            endcase
        end
    end
endmodule // wgsd_ovr
`default_nettype wire

// ---- logic/wgsd_top.v ----
// Summary of operation
// - software setting shutdown bit forces shutdown
// - no auto-restart: shutdown holds while bit set
// - auto-restart clears bit, resume next rising edge
// - enabled low source overrides outputs at once
// - sources: comparator1, comparator2, logic cell, pin
// - level sensitive; hold until source disabled
// - bd field drives b/d, ac field a/c
// - 11 one, 10 zero, 01 float, 00 inactive
// - each rise of the shutdown bit while enabled sets interrupt flag
// - restart blocked until cause gone
// - software clears bit, resume on rising edge
// - software clear ignored while condition present
// - hardware clears bit when conditions removed
// - keeps running in sleep with inputs
// - enable starts from shutdown state
// - load request waits falling then rising edge
// - load request only settable once enabled
// - three-bit mode field, 110/111 reserved
//
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "wgsd_defs.vh"
module wgsd_top (
    // clock and reset
    input wire i_core_clk,
    input wire i_arst_n,
    // register port
    input wire [`WGSD_ADDR_W-1:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [7:0] o_rdata,
    // data input and shutdown sources, asynchronous
    input wire i_data,
    input wire i_cmp1_n,
    input wire i_cmp2_n,
    input wire i_lc2_n,
    input wire i_pin_n,
    // polarity and normal waveform from the steering path
    input wire [3:0] i_pol,
    input wire [3:0] i_wave,
    // pins a..d in bits 0..3
    output wire [3:0] o_out,
    output wire [3:0] o_out_oe,
    // status towards the rest of the chip
    output wire o_enable,
    output wire [2:0] o_mode,
    output wire o_buf_load,
    output reg o_irq_flag
);
    // registers
    reg [7:0] ctrl0_r; // enable, mode; load request held in ld_r
    reg [7:0] sdctl_r; // shutdown, restart, levels
    reg [7:0] sdsrc_r; // source enables
    reg sd_r; // shutdown status bit
    reg sd_nxt;
    reg ld_r; // load request pending
    reg ld_fall_r; // falling edge seen since request
    reg data_d_r; // previous synced data
    reg run_r; // normal output active
    reg irq_r; // waveform interrupt flag
    reg ld_pulse_r; // one-cycle buffer load
    // synced sources
    wire data_s;
    wire [`WGSD_SRC_W-1:0] src_n_s;
    wire [`WGSD_SRC_W-1:0] src_en;
    wire hw_req_s; // synced request for the status bit
    wire hw_req_a; // raw request for the outputs
    wire rise;
    wire fall;
    wire wr_ctrl0;
    wire wr_sdctl;
    wire en;
    wire shut_now;
    wire [1:0] lvl_bd;
    wire [1:0] lvl_ac;
    wire [3:0] raw_n;
    wire wr_sdsrc; // source enable write
    wire wr_stat; // status write, flag clear

    // one register write decode; a wider address only
    // changes the offsets, never this compare
    function wgsd_hit(
        input strobe,
        input [`WGSD_ADDR_W-1:0] addr,
        input [`WGSD_ADDR_W-1:0] off
    );
        wgsd_hit = strobe && (addr == off);
    endfunction

    // edge of the synced data input against its last value;
    // the last sample resets low, so a false rise may follow
    // reset, harmless because shutdown is forced until enabled
    function wgsd_edge(
        input now,
        input prev,
        input want_rise
    );
        if (want_rise)
            wgsd_edge = now & ~prev;
        else
            wgsd_edge = ~now & prev;
    endfunction

    assign raw_n = {i_pin_n, i_lc2_n, i_cmp2_n, i_cmp1_n};

    // data input synchroniser
    wgsd_sync #(.W(1)) u_dsync (
        .i_core_clk(i_core_clk),
        .i_arst_n(i_arst_n),
        .i_async(i_data),
        .o_sync(data_s)
    );
    // shutdown source synchroniser, idle high after reset is
    // not guaranteed, so inversion keeps inactive as zero
    wgsd_sync #(.W(`WGSD_SRC_W)) u_ssync (
        .i_core_clk(i_core_clk),
        .i_arst_n(i_arst_n),
        .i_async(~raw_n),
        .o_sync(src_n_s)
    );

    assign src_en = sdsrc_r[`WGSD_SRC_W-1:0];
    assign hw_req_s = |(src_n_s & src_en);
    // unsynced path so the pins react without a clock
    assign hw_req_a = |(~raw_n & src_en);
    assign en = ctrl0_r[`WGSD_BIT_EN];
    assign rise = wgsd_edge(data_s, data_d_r, 1'b1);
    assign fall = wgsd_edge(data_s, data_d_r, 1'b0);
    // register write strobes, one per register
    assign wr_ctrl0 = wgsd_hit(i_wr, i_addr, `WGSD_OFF_CTRL0);
    assign wr_sdctl = wgsd_hit(i_wr, i_addr, `WGSD_OFF_SDCTL);
    assign wr_sdsrc = wgsd_hit(i_wr, i_addr, `WGSD_OFF_SDSRC);
    assign wr_stat = wgsd_hit(i_wr, i_addr, `WGSD_OFF_STAT);

    // shutdown status next value; later branches win, so the
    // priority runs from the last branch up: disable, source, software
    always @* begin
        // hold by default
        sd_nxt = sd_r;
        // software write to the shutdown bit
        if (wr_sdctl) begin
            if (i_wdata[`WGSD_BIT_SD])
                sd_nxt = 1'b1; // software shutdown
            else if (!hw_req_s)
                sd_nxt = 1'b0; // clear only when cause gone
        end
        // restart option clears once every cause is gone
        if (sd_r && sdctl_r[`WGSD_BIT_REN] && !hw_req_s
                && !(wr_sdctl && i_wdata[`WGSD_BIT_SD]))
            sd_nxt = 1'b0; // auto clear
        // an enabled low source keeps the bit set
        if (hw_req_s)
            sd_nxt = 1'b1; // level holds it set
        // a disabled block always sits in shutdown
        if (!en)
            sd_nxt = 1'b1; // start disabled from shutdown
    end

    // shutdown, run and interrupt state
    always @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sd_r <= 1'b1;
            run_r <= 1'b0;
            irq_r <= 1'b0;
            data_d_r <= 1'b0;
        end else begin
            data_d_r <= data_s;
            sd_r <= sd_nxt;
            // event is the rise of the status bit while enabled
            if (en && sd_nxt && !sd_r)
                irq_r <= 1'b1;
            else if (wr_stat && i_wdata[`WGSD_BIT_IRQ])
                irq_r <= 1'b0; // write one to clear, set wins
            if (sd_nxt)
                run_r <= 1'b0;
            else if (rise)
                run_r <= 1'b1; // resume on rising edge
        end
    end

    // control and configuration registers
    always @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ctrl0_r <= `WGSD_CTRL0_RST;
            sdctl_r <= `WGSD_SDCTL_RST;
            sdsrc_r <= `WGSD_SDSRC_RST;
        end else begin
            if (wr_ctrl0) begin
                ctrl0_r[`WGSD_BIT_EN] <= i_wdata[`WGSD_BIT_EN];
                ctrl0_r[`WGSD_MODE_HI:`WGSD_MODE_LO] <=
                    i_wdata[`WGSD_MODE_HI:`WGSD_MODE_LO];
            end
            // low two bits unimplemented, stored as zero
            if (wr_sdctl)
                sdctl_r <= i_wdata & `WGSD_SDCTL_MASK_LEVELS;
            // upper source bits unimplemented
            if (wr_sdsrc)
                sdsrc_r <= {4'h0, i_wdata[`WGSD_SRC_W-1:0]};
        end
    end

    // buffer load request sequencing
    always @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ld_r <= 1'b0;
            ld_fall_r <= 1'b0;
            ld_pulse_r <= 1'b0;
        end else begin
            ld_pulse_r <= 1'b0;
            if (!en) begin
                ld_r <= 1'b0;
                ld_fall_r <= 1'b0;
            end else if (wr_ctrl0 && i_wdata[`WGSD_BIT_LD] && !ld_r) begin
                ld_r <= 1'b1; // only when already enabled
                ld_fall_r <= 1'b0;
            end else if (ld_r && !ld_fall_r && fall) begin
                ld_fall_r <= 1'b1;
            end else if (ld_r && ld_fall_r && rise) begin
                ld_r <= 1'b0; // hardware clear
                ld_fall_r <= 1'b0;
                ld_pulse_r <= 1'b1;
            end
        end
    end

    // read data one cycle after the strobe
    always @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rdata <= 8'h00;
            o_irq_flag <= 1'b0;
        end else begin
            o_irq_flag <= irq_r;
            o_rdata <= 8'h00;
            if (i_rd) begin
                case (i_addr)
                    `WGSD_OFF_CTRL0: o_rdata <= {en, ld_r, 3'h0,
                        ctrl0_r[`WGSD_MODE_HI:`WGSD_MODE_LO]};
                    // live status bit in place of the stored one
                    `WGSD_OFF_SDCTL: o_rdata <= {sd_r,
                        sdctl_r[`WGSD_BIT_REN:`WGSD_AC_LO], 2'h0};
                    `WGSD_OFF_SDSRC: o_rdata <= sdsrc_r;
                    // run above the interrupt flag
                    `WGSD_OFF_STAT: o_rdata <= {6'h00, run_r, irq_r};
                    default: o_rdata <= 8'h00;
                endcase
            end
        end
    end

    // override selection; runs on core clock, no sleep gating
    // the raw source path skips the synchroniser, so even a short
    // glitch on an enabled source blanks the outputs, by intent
    assign shut_now = sd_r | hw_req_a | !run_r;
    assign lvl_bd = sdctl_r[`WGSD_BD_HI:`WGSD_BD_LO];
    assign lvl_ac = sdctl_r[`WGSD_AC_HI:`WGSD_AC_LO];

    // pins a and c from ac field, b and d from bd field
    // pin a, ac field
    wgsd_ovr u_ova (
        .i_level(lvl_ac),
        .i_pol(i_pol[0]),
        .i_shut(shut_now),
        .i_norm(i_wave[0]),
        .o_val(o_out[0]),
        .o_oe(o_out_oe[0])
    );
    // pin b, bd field
    wgsd_ovr u_ovb (
        .i_level(lvl_bd),
        .i_pol(i_pol[1]),
        .i_shut(shut_now),
        .i_norm(i_wave[1]),
        .o_val(o_out[1]),
        .o_oe(o_out_oe[1])
    );
    // pin c, ac field
    wgsd_ovr u_ovc (
        .i_level(lvl_ac),
        .i_pol(i_pol[2]),
        .i_shut(shut_now),
        .i_norm(i_wave[2]),
        .o_val(o_out[2]),
        .o_oe(o_out_oe[2])
    );
    // pin d, bd field
    wgsd_ovr u_ovd (
        .i_level(lvl_bd),
        .i_pol(i_pol[3]),
        .i_shut(shut_now),
        .i_norm(i_wave[3]),
        .o_val(o_out[3]),
        .o_oe(o_out_oe[3])
    );

    assign o_enable = en;
    assign o_mode = ctrl0_r[`WGSD_MODE_HI:`WGSD_MODE_LO];
    assign o_buf_load = ld_pulse_r;
endmodule // wgsd_top
`default_nettype wire

// ---- verification/wgsd_top_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
// port-level watcher of the register side and status outputs
module wgsd_chk (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_arst_n,
    // register port
    input wire logic [2:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    // status
    input wire logic o_enable,
    input wire logic [2:0] o_mode,
    input wire logic o_buf_load,
    input wire logic o_irq_flag
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_arst_n);
    // decoded strobes
    wire c0_wr = i_wr && i_addr == 3'h0;
    wire c0_rd = i_rd && i_addr == 3'h0;
    wire irq_clr = i_wr && i_addr == 3'h3 && i_wdata[0];
    chk_en_write: assert property (
        c0_wr |=> o_enable == $past(i_wdata[7])) else $error("enable lost");
    chk_mode_write: assert property (
        c0_wr |=> o_mode == $past(i_wdata[2:0])) else $error("mode lost");
    chk_ctrl_read: assert property (
        c0_rd |=> o_rdata[5:3] == 3'h0 && o_rdata[7] == $past(o_enable))
        else $error("control read wrong");
    chk_idle_rdata: assert property (
        !i_rd |=> o_rdata == 8'h00) else $error("read data not idle");
    // flag only drops after a clearing write
    chk_irq_hold: assert property (
        o_irq_flag && !irq_clr && !$past(irq_clr) |=> o_irq_flag)
        else $error("irq flag dropped");
    chk_irq_read: assert property (
        i_rd && i_addr == 3'h3 |=> o_rdata[0] == o_irq_flag)
        else $error("irq status mismatch");
    chk_load_pulse: assert property (
        o_buf_load |=> !o_buf_load) else $error("load not a pulse");
    // load needs enable long before: set request, then two edges
    chk_load_enabled: assert property (
        o_buf_load |-> $past(o_enable, 3)) else $error("load too early");
endmodule // wgsd_chk
bind wgsd_top wgsd_chk wgsd_chk_inst (
    .i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_enable(o_enable), .o_mode(o_mode), .o_buf_load(o_buf_load),
    .o_irq_flag(o_irq_flag)
);
`default_nettype wire

// ---- verification/wgsd_sw_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// switch drivers at the pins
module wgsd_sw_model (
    // clock
    input wire logic i_core_clk,
    // pin drive from the block
    input wire logic [3:0] i_out,
    input wire logic [3:0] i_out_oe,
    // levels seen by the switches
    output logic [3:0] o_gate
);
    logic [3:0] last_r = 4'h0; // last level seen
    // a floating pin toggles, so a held value never passes
    always @(posedge i_core_clk) begin
        last_r <= o_gate;
    end
    assign o_gate = (i_out & i_out_oe) | (~last_r & ~i_out_oe);
endmodule // wgsd_sw_model
`default_nettype wire

// ---- verification/wgsd_top_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
// self-checking bench for shutdown and control
module wgsd_top_bench;
    logic i_core_clk = 1'b0;
    logic i_arst_n = 1'b0;
    logic [2:0] i_addr = 3'h0;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic i_data = 1'b1;
    logic [3:0] src_n = 4'hF; // cmp1, cmp2, logic cell, pin
    logic [3:0] i_pol = 4'h0;
    logic [3:0] i_wave = 4'h6;
    wire [7:0] o_rdata;
    wire [3:0] o_out, o_out_oe, gate;
    wire o_enable, o_buf_load, o_irq_flag;
    wire [2:0] o_mode;
    logic [7:0] rv; // last read data
    logic load_seen = 1'b0;
    int error_cnt = 0;
    int num_checks = 0;
    wgsd_top wgsd_top_inst (
        .i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_data(i_data), .i_cmp1_n(src_n[0]), .i_cmp2_n(src_n[1]),
        .i_lc2_n(src_n[2]), .i_pin_n(src_n[3]), .i_pol(i_pol),
        .i_wave(i_wave), .o_out(o_out), .o_out_oe(o_out_oe),
        .o_enable(o_enable), .o_mode(o_mode), .o_buf_load(o_buf_load),
        .o_irq_flag(o_irq_flag)
    );
    wgsd_sw_model wgsd_sw_model_inst (
        .i_core_clk(i_core_clk), .i_out(o_out), .i_out_oe(o_out_oe),
        .o_gate(gate)
    );
    always #50 i_core_clk = ~i_core_clk;
    // load pulses are remembered until a scenario looks
    always @(posedge i_core_clk) if (o_buf_load) load_seen <= 1'b1;
    task automatic chk(input string nm, input logic [7:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge i_core_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [2:0] a);
        @(posedge i_core_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        #1;
        rv = o_rdata;
    endtask
    // data low then high, long enough for the synchroniser
    task automatic pulse();
        repeat (5) @(posedge i_core_clk);
        i_data <= 1'b0;
        repeat (5) @(posedge i_core_clk);
        i_data <= 1'b1;
        repeat (5) @(posedge i_core_clk);
        #1;
    endtask
    // pin drive, enables and what the switches see
    task automatic pins(input logic [3:0] v, oe);
        #1;
        chk("oe", {4'h0, o_out_oe}, {4'h0, oe});
        chk("pins", {4'h0, o_out & oe}, {4'h0, v});
        chk("gate", {4'h0, gate & oe}, {4'h0, v});
    endtask
    task automatic t_reset();
        rd(3'h0);
        chk("ctrl0", rv, 8'h00);
        rd(3'h1);
        chk("levels", rv & 8'h7F, 8'h14);
        pins(4'h0, 4'h0);
        rd(3'h7);
        chk("unmapped", rv, 8'h00);
    endtask
    task automatic t_ctrl();
        wr(3'h1, 8'hB8); // levels before enable
        pins(4'hA, 4'hF);
        load_seen = 1'b0;
        wr(3'h0, 8'hFD); // enable last
        rd(3'h0);
        chk("ctrl0", rv, 8'h85);
        pulse();
        chk("no load", {7'h0, load_seen}, 8'h00);
        pins(4'hA, 4'hF);
        for (int m = 0; m < 6; m++) begin
            wr(3'h0, 8'h80 | m[7:0]);
            chk("mode", {5'h0, o_mode}, {5'h0, m[2:0]});
        end
        i_pol <= 4'h5;
        wr(3'h1, 8'h80);
        pins(4'h5, 4'hF);
        wr(3'h1, 8'h94);
        pins(4'h0, 4'h0);
        wr(3'h1, 8'hB8);
        wr(3'h1, 8'h38);
        rd(3'h1);
        chk("sd clear", rv, 8'h38);
        pins(4'hA, 4'hF);
        pulse();
        pins(i_wave, 4'hF);
    endtask
    task automatic t_src();
        for (int s = 0; s < 4; s++) begin
            wr(3'h3, 8'h01);
            wr(3'h2, 8'h01 << s);
            src_n[s] <= 1'b0;
            pins(4'hA, 4'hF);
            // let the source pass the synchroniser before the clear
            repeat (3) @(posedge i_core_clk);
            wr(3'h1, 8'h38);
            rd(3'h1);
            chk("sd held", rv, 8'hB8);
            rd(3'h3);
            chk("irq", rv & 8'h01, 8'h01);
            src_n[s] <= 1'b1;
            repeat (4) @(posedge i_core_clk);
            wr(3'h1, 8'h38);
            pulse();
            pins(i_wave, 4'hF);
        end
        src_n[0] <= 1'b0;
        wr(3'h2, 8'h01);
        wr(3'h2, 8'h00);
        wr(3'h1, 8'h38);
        rd(3'h1);
        chk("sd off", rv, 8'h38);
        src_n[0] <= 1'b1;
        wr(3'h3, 8'h01);
        rd(3'h3);
        chk("irq clr", rv & 8'h01, 8'h00);
    endtask
    task automatic t_auto();
        wr(3'h1, 8'h78);
        wr(3'h2, 8'h02);
        src_n[1] <= 1'b0;
        pins(4'hA, 4'hF);
        repeat (4) @(posedge i_core_clk);
        src_n[1] <= 1'b1;
        repeat (6) @(posedge i_core_clk);
        rd(3'h1);
        chk("auto clr", rv, 8'h78);
        pulse();
        pins(i_wave, 4'hF);
        wr(3'h1, 8'hF8);
        pins(4'hA, 4'hF);
        pulse();
        pins(i_wave, 4'hF);
    endtask
    task automatic t_load();
        load_seen = 1'b0;
        wr(3'h0, 8'hC5);
        rd(3'h0);
        chk("ld set", rv, 8'hC5);
        pulse();
        chk("load", {7'h0, load_seen}, 8'h01);
        rd(3'h0);
        chk("ld clr", rv, 8'h85);
    endtask
    task automatic results();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge i_core_clk);
        i_arst_n <= 1'b1;
        t_reset();
        t_ctrl();
        t_src();
        t_auto();
        t_load();
        results();
    end
    // watchdog far beyond the few hundred cycles of the run
    initial begin
        #2000000;
        error_cnt++;
        results();
    end
endmodule // wgsd_top_bench
`default_nettype wire
